// ### rtl/smrs_slave.sv
`timescale 1ns/1ns
`include "smrs_params.svh"
module smrs_slave #(
  parameter int unsigned TIMEOUT_CYC = `SMRS_TIMEOUT_CYC
) (
  input wire logic i_clk_sys,                 // system clock, 250 MHz
  input wire logic i_rst_n,                   // async reset, active low
  input wire logic i_scl,                     // serial clock pin
  input wire logic i_sda,                     // serial data pin level
  output logic o_sda_out,                     // serial data drive value
  output logic o_sda_oe,                      // high while pulling data low
  input wire logic [2:0] i_addr_sel,          // address select pins
  input wire logic [7:0] i_rd_data,           // byte at o_reg_req.ptr
  output smrs_pkg::smrs_reg_req_s o_reg_req,  // pointer and write strobe
  output logic o_rd_strobe,                   // pulse: byte taken for read
  output smrs_pkg::smrs_hold_s o_hold         // update block for second byte
);
  import smrs_pkg::*;

  function automatic logic is_temp_first(input logic [7:0] a);
    is_temp_first = (a >= `SMRS_TEMP_FIRST) && (a <= `SMRS_TEMP_LAST) && !a[0];
  endfunction

  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic [2:0] sel_s1_reg, sel_s2_reg;
  logic [1:0] settle_reg;
  logic sel_done_reg;
  logic [6:0] own_addr_reg;
  smrs_state_e state_reg;
  logic [3:0] bit_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic first_reg;
  logic rw_reg;
  logic mack_reg;
  logic [7:0] ptr_reg;
  logic wr_en_reg;
  logic [7:0] wr_data_reg;
  logic rd_strobe_reg;
  logic hold_reg;
  logic [7:0] hold_addr_reg;
  logic timer_expire;

  // edges come from the second sync flop and its delayed copy only
  wire logic scl_rise = scl_s2_reg && !scl_d_reg;
  wire logic scl_fall = !scl_s2_reg && scl_d_reg;
  wire logic start_cond = scl_s2_reg && scl_d_reg && !sda_s2_reg && sda_d_reg;
  wire logic stop_cond = scl_s2_reg && scl_d_reg && sda_s2_reg && !sda_d_reg;
  wire logic [7:0] rx_full = {rx_reg[6:0], sda_s2_reg};
  wire logic addr_hit = sel_done_reg && (rx_reg[7:1] == own_addr_reg);
  wire logic byte_done = scl_fall && (bit_reg == `SMRS_BIT_LAST);
  wire logic rd_load = scl_fall && ((state_reg == SMRS_ADDR_ACK && rw_reg)
                       || (state_reg == SMRS_RD_ACK && mack_reg));
  wire logic hold_start = rd_load && is_temp_first(ptr_reg);
  wire logic hold_done = rd_load && hold_reg && (ptr_reg == hold_addr_reg);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      sel_s1_reg <= 3'h0;
      sel_s2_reg <= 3'h0;
    end else begin
      scl_s1_reg <= i_scl;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg <= scl_s2_reg;
      sda_s1_reg <= i_sda;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg <= sda_s2_reg;
      sel_s1_reg <= i_addr_sel;
      sel_s2_reg <= sel_s1_reg;
    end
  end

  // RULE_14 one-time address capture
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      settle_reg <= 2'h0;
      sel_done_reg <= 1'b0;
      own_addr_reg <= `SMRS_BASE_ADDR;
    end else if (!sel_done_reg) begin
      settle_reg <= settle_reg + 2'h1;
      if (settle_reg == `SMRS_SEL_SETTLE) begin
        sel_done_reg <= 1'b1;
        own_addr_reg <= `SMRS_BASE_ADDR + {4'h0, sel_s2_reg};
      end
    end
  end

  // RULE_01 transfer sequencer
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= SMRS_IDLE;
      bit_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'hFF;
      first_reg <= 1'b0;
      rw_reg <= 1'b0;
      mack_reg <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (start_cond) begin
      // RULE_05 restart keeps pointer
      state_reg <= SMRS_ADDR;
      bit_reg <= 4'h0;
      o_sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state_reg <= SMRS_IDLE;
      o_sda_oe <= 1'b0;
    end else begin
      case (state_reg)
        SMRS_ADDR, SMRS_WR_BYTE: begin
          if (scl_rise) begin
            rx_reg <= rx_full;
            bit_reg <= bit_reg + 4'h1;
          end
          if (byte_done) begin
            if (state_reg == SMRS_WR_BYTE) begin
              // RULE_16 ack pointer and data
              o_sda_oe <= 1'b1;
              state_reg <= SMRS_WR_ACK;
            end else if (addr_hit) begin
              // RULE_16 ack own address
              o_sda_oe <= 1'b1;
              rw_reg <= rx_reg[0];
              state_reg <= SMRS_ADDR_ACK;
            end else begin
              // RULE_15 foreign address ignored
              state_reg <= SMRS_IGNORE;
            end
          end
        end
        SMRS_ADDR_ACK: begin
          if (scl_fall) begin
            bit_reg <= 4'h0;
            if (rw_reg) begin
              // RULE_11 data from held pointer
              tx_reg <= i_rd_data;
              o_sda_oe <= !i_rd_data[7];
              state_reg <= SMRS_RD_BYTE;
            end else begin
              o_sda_oe <= 1'b0;
              first_reg <= 1'b1;
              state_reg <= SMRS_WR_BYTE;
            end
          end
        end
        SMRS_WR_ACK: begin
          if (scl_fall) begin
            o_sda_oe <= 1'b0;
            first_reg <= 1'b0;
            bit_reg <= 4'h0;
            state_reg <= SMRS_WR_BYTE;
          end
        end
        SMRS_RD_BYTE: begin
          if (scl_fall) begin
            bit_reg <= bit_reg + 4'h1;
            tx_reg <= {tx_reg[6:0], 1'b1};
            o_sda_oe <= !tx_reg[6] && (bit_reg != `SMRS_TX_LAST);
            if (bit_reg == `SMRS_TX_LAST) state_reg <= SMRS_RD_ACK;
          end
        end
        SMRS_RD_ACK: begin
          if (scl_rise) mack_reg <= !sda_s2_reg;
          if (scl_fall) begin
            bit_reg <= 4'h0;
            if (mack_reg) begin
              // RULE_06 next contiguous byte
              tx_reg <= i_rd_data;
              o_sda_oe <= !i_rd_data[7];
              state_reg <= SMRS_RD_BYTE;
            end else begin
              // RULE_16 line released after nack
              o_sda_oe <= 1'b0;
              state_reg <= SMRS_IGNORE;
            end
          end
        end
        SMRS_IDLE, SMRS_IGNORE: o_sda_oe <= 1'b0;
        default: begin
          state_reg <= SMRS_IDLE;
          o_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // on reads the pointer moves on the master's ack rise so the read port settles before load
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_reg <= `SMRS_PTR_RESET;
      wr_en_reg <= 1'b0;
      wr_data_reg <= 8'h00;
    end else begin
      wr_en_reg <= 1'b0;
      if (byte_done && state_reg == SMRS_WR_BYTE) begin
        if (first_reg) begin
          // RULE_10 pointer byte loads pointer
          ptr_reg <= rx_reg;
        end else begin
          // RULE_02 data byte stored
          wr_en_reg <= 1'b1;
          wr_data_reg <= rx_reg;
        end
      end
      // RULE_03 advance after each written byte
      if (scl_fall && state_reg == SMRS_WR_ACK && !first_reg) ptr_reg <= ptr_reg + 8'h01;
      // RULE_12 no advance on nack, so receive byte repeats
      if (scl_rise && state_reg == SMRS_RD_ACK && !sda_s2_reg) ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // RULE_08 hold second temperature byte
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_reg <= 1'b0;
      hold_addr_reg <= 8'h00;
      rd_strobe_reg <= 1'b0;
    end else begin
      rd_strobe_reg <= rd_load;
      if (hold_start) begin
        hold_reg <= 1'b1;
        hold_addr_reg <= ptr_reg + 8'h01;
      end else if (hold_done || timer_expire) begin
        hold_reg <= 1'b0;
      end
    end
  end

  // RULE_09 release on timeout
  smrs_hold_timer #(
    .TIMEOUT_CYC(TIMEOUT_CYC)
  ) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_start(hold_start),
    .i_run(hold_reg),
    .o_expire(timer_expire)
  );

  assign o_sda_out = 1'b0;
  assign o_reg_req = '{wr_en: wr_en_reg, ptr: ptr_reg, wr_data: wr_data_reg};
  assign o_rd_strobe = rd_strobe_reg;
  assign o_hold = '{active: hold_reg, addr: hold_addr_reg};
endmodule // smrs_slave

// ### rtl/smrs_params.svh
// Summary of operation
// RULE_01 - smbus slave: byte, short and burst transfers
// RULE_02 - write: address, pointer byte, then data
// RULE_03 - burst write advances pointer per byte
// RULE_04 - master ends every write with stop
// RULE_05 - read: pointer write, restart, read data
// RULE_06 - burst read advances pointer per byte
// RULE_07 - master ends read with nack, stop
// RULE_08 - first temperature byte read blocks second's update
// RULE_09 - hold released after smbus timeout
// RULE_10 - send byte only loads the pointer
// RULE_11 - receive byte returns previously pointed register
// RULE_12 - receive byte leaves pointer unchanged
// RULE_13 - multimaster short transfers need care
// RULE_14 - address select sampled once at start
// RULE_15 - pointer kept; foreign addresses not acknowledged
// RULE_16 - ack address, pointer, data; release on nack
`ifndef SMRS_PARAMS_SVH
`define SMRS_PARAMS_SVH

// base of the eight slave addresses; value arbitrary
`define SMRS_BASE_ADDR 7'h38
`define SMRS_PTR_RESET 8'h00
// temperature value pairs live at even/odd pointer pairs in this range
`define SMRS_TEMP_FIRST 8'h00
`define SMRS_TEMP_LAST 8'h0F
`define SMRS_TIMEOUT_US 35000
`define SMRS_CLK_MHZ 250
`define SMRS_TIMEOUT_CYC (`SMRS_TIMEOUT_US * `SMRS_CLK_MHZ)
`define SMRS_SEL_SETTLE 2'h2
`define SMRS_BIT_LAST 4'h8
`define SMRS_TX_LAST 4'h7

`endif

// ### rtl/smrs_pkg.sv
package smrs_pkg;
  typedef enum logic [2:0] {
    SMRS_IDLE,
    SMRS_ADDR,
    SMRS_ADDR_ACK,
    SMRS_WR_BYTE,
    SMRS_WR_ACK,
    SMRS_RD_BYTE,
    SMRS_RD_ACK,
    SMRS_IGNORE
  } smrs_state_e;

  typedef struct packed {
    logic wr_en;
    logic [7:0] ptr;
    logic [7:0] wr_data;
  } smrs_reg_req_s;

  typedef struct packed {
    logic active;
    logic [7:0] addr;
  } smrs_hold_s;
endpackage

// ### rtl/smrs_hold_timer.sv
`timescale 1ns/1ns
`include "smrs_params.svh"
module smrs_hold_timer #(
  parameter int unsigned TIMEOUT_CYC = `SMRS_TIMEOUT_CYC
) (
  input wire logic i_clk_sys,  // system clock
  input wire logic i_rst_n,    // async reset, active low
  input wire logic i_start,    // restart the count
  input wire logic i_run,      // count while high
  output logic o_expire        // one-cycle pulse at timeout
);
  logic [23:0] cnt_reg;
  wire logic at_end = (cnt_reg == TIMEOUT_CYC[23:0] - 24'h000001);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 24'h000000;
      o_expire <= 1'b0;
    end else begin
      o_expire <= i_run && !i_start && at_end;
      if (i_start || !i_run || at_end) cnt_reg <= 24'h000000;
      else cnt_reg <= cnt_reg + 24'h000001;
    end
  end
endmodule // smrs_hold_timer

// ### testbench/smrs_slave_properties.sv
`timescale 1ns/1ns
module smrs_slave_properties #(
  parameter int unsigned TIMEOUT_CYC = 600
) (
  input wire logic i_clk_sys,                    // system clock
  input wire logic i_rst_n,                      // async reset, active low
  input wire logic i_scl,                        // serial clock pin
  input wire logic o_sda_out,                    // data drive value
  input wire logic o_sda_oe,                     // data pull enable
  input wire logic [7:0] i_rd_data,              // byte at pointer
  input wire smrs_pkg::smrs_reg_req_s o_reg_req, // pointer and write strobe
  input wire logic o_rd_strobe,                  // byte load pulse
  input wire smrs_pkg::smrs_hold_s o_hold        // second byte hold
);
  import smrs_pkg::*;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  int unsigned hold_cnt_reg;
  // a fresh byte load may restart the hold, so age it from the strobe
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) hold_cnt_reg <= 0;
    else if (!o_hold.active || o_rd_strobe) hold_cnt_reg <= 0;
    else hold_cnt_reg <= hold_cnt_reg + 1;
  end
  drive_low_a: assert property (o_sda_out == 1'b0)
    else $error("data drive value not low");
  wr_pulse_a: assert property (o_reg_req.wr_en |=> !o_reg_req.wr_en)
    else $error("write strobe longer than one cycle");
  wr_ack_a: assert property (o_reg_req.wr_en |-> o_sda_oe)
    else $error("written byte not acknowledged");
  rd_pulse_a: assert property (o_rd_strobe |=> !o_rd_strobe)
    else $error("read strobe longer than one cycle");
  rd_first_bit_a: assert property (o_rd_strobe |-> o_sda_oe == !$past(i_rd_data[7]))
    else $error("first read bit differs from register");
  scl_low_change_a: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data changed while clock high");
  hold_pair_a: assert property (o_hold.active |-> o_hold.addr[0] && o_hold.addr[7:4] == 4'h0)
    else $error("hold on a non second byte");
  hold_load_a: assert property ($rose(o_hold.active) |-> ##[0:2] o_rd_strobe)
    else $error("hold set without a byte load");
  hold_expire_a: assert property (hold_cnt_reg <= TIMEOUT_CYC + 8)
    else $error("hold outlived the timeout");
  cover property (o_reg_req.wr_en);
  cover property (o_rd_strobe);
  cover property ($fell(o_hold.active));
endmodule // smrs_slave_properties

bind smrs_slave smrs_slave_properties #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_scl(i_scl), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .i_rd_data(i_rd_data), .o_reg_req(o_reg_req),
  .o_rd_strobe(o_rd_strobe), .o_hold(o_hold));

// ### testbench/smrs_host_model.sv
`timescale 1ns/1ns
module smrs_host_model (
  input wire logic i_clk_sys,  // aligns edges
  input wire logic i_sda,      // resolved data wire
  output logic o_scl,          // idles high
  output logic o_sda_pull      // high while pulling low
);
  int gap = 0;
  initial begin
    o_scl = 1'b1;
    o_sda_pull = 1'b0;
  end
  // data moves mid-low, sampled mid-high; gap stretches the low phase
  task automatic bit_io(input logic b, output logic r);
    o_sda_pull = !b;
    #(20 + gap) o_scl = 1'b1;
    #20 r = i_sda;
    #20 o_scl = 1'b0;
    #20;
  endtask
  task automatic start_cond();
    @(negedge i_clk_sys);
    o_sda_pull = 1'b0;
    #20 o_scl = 1'b1;
    #20 o_sda_pull = 1'b1;
    #20 o_scl = 1'b0;
    #20;
  endtask
  task automatic stop_cond();
    o_sda_pull = 1'b1;
    #20 o_scl = 1'b1;
    #20 o_sda_pull = 1'b0;
    #40;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // last byte of a read is refused
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule // smrs_host_model

// ### testbench/smrs_slave_bench.sv
`timescale 1ns/1ns
`include "smrs_params.svh"
`define CHECK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module smrs_slave_bench;
  import smrs_pkg::*;
  localparam int unsigned TMO = 600;
  logic i_clk_sys, i_rst_n, scl, host_pull, sda_oe, sda_out, rd_strobe, ack;
  logic [2:0] addr_sel;
  logic [6:0] dev;
  logic [7:0] b, p;
  logic [7:0] regs [256];
  logic [7:0] model [256];
  smrs_reg_req_s reg_req;
  smrs_hold_s hold;
  int fail_count = 0, checks_done = 0, cycles = 0, seed = 29, exp_ptr = 0;
  wire sda = !(host_pull || sda_oe);
  smrs_slave #(.TIMEOUT_CYC(TMO)) uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_addr_sel(addr_sel), .i_rd_data(regs[reg_req.ptr]), .o_reg_req(reg_req),
    .o_rd_strobe(rd_strobe), .o_hold(hold));
  smrs_host_model host (.i_clk_sys(i_clk_sys), .i_sda(sda), .o_scl(scl), .o_sda_pull(host_pull));
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    if (reg_req.wr_en) regs[reg_req.ptr] <= reg_req.wr_data;
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] pp, input int n);
    host.start_cond();
    host.wbyte({dev, 1'b0}, ack);
    `CHECK("addr ack", 1'b1, ack)
    host.wbyte(pp, ack);
    exp_ptr = pp;
    for (int i = 0; i < n; i++) begin
      b = 8'($random(seed));
      host.wbyte(b, ack);
      `CHECK("data ack", 1'b1, ack)
      model[exp_ptr] = b;
      exp_ptr = (exp_ptr + 1) % 256;
    end
    host.stop_cond();
    `CHECK("wr ptr", exp_ptr[7:0], reg_req.ptr)
  endtask
  task automatic rd(input logic setp, input logic [7:0] pp, input int n);
    host.start_cond();
    if (setp) begin
      host.wbyte({dev, 1'b0}, ack);
      host.wbyte(pp, ack);
      exp_ptr = pp;
      host.start_cond();
    end
    host.wbyte({dev, 1'b1}, ack);
    `CHECK("rd addr ack", 1'b1, ack)
    for (int i = 0; i < n; i++) begin
      host.rbyte(i == n - 1, b);
      `CHECK("rd data", model[exp_ptr], b)
      if (i < n - 1) exp_ptr = (exp_ptr + 1) % 256;
    end
    host.stop_cond();
    `CHECK("rd ptr", exp_ptr[7:0], reg_req.ptr)
  endtask
  initial begin
    i_rst_n = 1'b0;
    addr_sel = 3'($random(seed));
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'($random(seed));
      model[i] = regs[i];
    end
    dev = 7'(`SMRS_BASE_ADDR + addr_sel);
    repeat (6) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    repeat (10) @(negedge i_clk_sys);
    host.start_cond();
    host.wbyte({dev ^ 7'h01, 1'b0}, ack);
    host.stop_cond();
    `CHECK("foreign ack", 1'b0, ack)
    wr(8'hFE, 3);
    rd(1'b1, 8'hFE, 3);
    wr(8'h21, 0);
    rd(1'b0, 8'h00, 1);
    rd(1'b0, 8'h00, 1);
    rd(1'b1, 8'h04, 1);
    `CHECK("hold on", 1'b1, hold.active)
    `CHECK("hold addr", 8'h05, hold.addr)
    repeat (TMO + 20) @(negedge i_clk_sys);
    `CHECK("hold expired", 1'b0, hold.active)
    rd(1'b1, 8'h04, 2);
    `CHECK("hold freed", 1'b0, hold.active)
    host.gap = 40;
    wr(8'h40, 2);
    rd(1'b1, 8'h40, 2);
    host.gap = 0;
    repeat (3) begin
      p = 8'($random(seed));
      wr(p, 3);
      rd(1'b1, p, 3);
    end
    stop_test();
  end
endmodule // smrs_slave_bench
